// file: design/power_save_mode_control.sv
/*
  power_save_mode_control: deep stop (halt) and light sleep (idle) state
  controller with idle timer, start-up delay, wake sources and APB slave.
  Assumes i_clock is the oscillator clock, pins are synchronous to it and
  an APB master drives the register port.
*/
// Functional notes
// - writing one to the halt flag stops clock and all timers.
// - watchdog inhibited in halt; enabled clock monitor drives fault output low.
// - halt exits on wake pin edge, clock-out rise (rc only), or reset.
// - on wakeup enable oscillator, start-up counter loads 256 ticks before core clock.
// - instruction-cycle tick is oscillator clock divided by ten.
// - rc start-up delay applied only when delay enable set; cleared on reset.
// - with halt disabled, halt flag writes do nothing and read zero.
// - in halt, clock input held high for rc, else high impedance.
// - writing one to idle flag stops all but oscillator, idle timer and watchdog.
// - both sleep states keep state and all timers except idle timer.
// - idle exits on reset, wake pin event or idle timer bit twelve toggle; the code exits on the bit eleven toggle.
// - each toggle sets wake timer pending; interrupt needs its enable bit.
// - idle with timer irq enabled runs the service routine, then continues.
// - idle with timer irq disabled resumes at the following instruction.
// - halt entry refused while any wake pin is enabled and pending.
`timescale 1ns/1ps
`default_nettype none

module power_save_mode_control #(
  parameter int WAKE_PINS = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // wake sources
  input wire logic [WAKE_PINS-1:0] i_wake_pins,
  input wire logic i_clock_out_pin,
  // power control
  output logic o_core_clock_enable,
  output logic o_oscillator_enable,
  output logic o_idle_timer_running,
  output logic o_watchdog_enable,
  output logic o_watchdog_fault_output_n,
  output logic o_clock_in_hold_high,
  output logic o_clock_in_hiz,
  // interrupts
  output logic o_wake_timer_irq,
  output logic o_irq
);

  initial begin
    if (WAKE_PINS < 1 || WAKE_PINS > 8) begin
      $error("WAKE_PINS must be 1 to 8");
    end
  end

  localparam int DIV_W = $clog2(power_save_pkg::TC_DIVIDE);
  localparam int SU_W = $clog2(power_save_pkg::STARTUP_LOAD) + 1;
  localparam int TW = power_save_pkg::IDLE_TIMER_WIDTH;
  localparam logic [DIV_W-1:0] DIV_LAST =
    DIV_W'(power_save_pkg::TC_DIVIDE - 1);
  localparam logic [SU_W-1:0] SU_LOAD = SU_W'(power_save_pkg::STARTUP_LOAD);

  power_save_pkg::pwr_state_t state_reg;
  power_save_pkg::ctrl_t ctrl_reg;
  power_save_pkg::option_t option_reg;
  logic [WAKE_PINS-1:0] wake_en_reg;
  logic [WAKE_PINS-1:0] wake_edge_reg;
  logic [WAKE_PINS-1:0] wake_pend_reg;
  logic [WAKE_PINS-1:0] pins_prev_reg;
  logic clock_out_prev_reg;
  logic [DIV_W-1:0] div_reg;
  logic [SU_W-1:0] startup_reg;
  logic [TW-1:0] idle_timer_reg;
  logic [power_save_pkg::EV_WIDTH-1:0] irq_status_reg;
  logic [power_save_pkg::EV_WIDTH-1:0] irq_mask_reg;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic wr_fire;
  logic setup;
  logic [7:0] addr;
  assign setup = i_psel & ~i_penable;
  assign wr_fire = i_psel & i_penable & o_pready & i_pwrite;
  assign addr = i_paddr;

  logic wr_ctrl;
  logic wr_opt;
  logic wr_wen;
  logic wr_wedge;
  logic wr_wpend;
  logic wr_irqs;
  logic wr_mask;
  assign wr_ctrl = wr_fire && addr == power_save_pkg::CTRL_OFS;
  assign wr_opt = wr_fire && addr == power_save_pkg::OPTION_CONFIG_OFS;
  assign wr_wen = wr_fire && addr == power_save_pkg::WAKE_EN_OFS;
  assign wr_wedge = wr_fire && addr == power_save_pkg::WAKE_EDGE_OFS;
  assign wr_wpend = wr_fire && addr == power_save_pkg::WAKE_PEND_OFS;
  assign wr_irqs = wr_fire && addr == power_save_pkg::IRQ_STATUS_OFS;
  assign wr_mask = wr_fire && addr == power_save_pkg::IRQ_MASK_OFS;

  ////////////////////////////////////////////////////////////////////////
  // wake event detection

  logic [WAKE_PINS-1:0] pin_edge;
  genvar g;
  generate
    for (g = 0; g < WAKE_PINS; g++) begin : g_edge
      // set in edge register selects falling, clear selects rising
      assign pin_edge[g] = wake_edge_reg[g] ?
        (pins_prev_reg[g] & ~i_wake_pins[g]) :
        (~pins_prev_reg[g] & i_wake_pins[g]);
    end
  endgenerate

  logic pin_wake;
  logic ckout_rise;
  logic halt_wake;
  logic halt_req;
  logic idle_req;
  assign pin_wake = |(pin_edge & wake_en_reg);
  assign ckout_rise = option_reg.rc_osc_select & ~clock_out_prev_reg &
    i_clock_out_pin;
  assign halt_wake = pin_wake | ckout_rise;

  assign halt_req = wr_ctrl & i_pwdata[power_save_pkg::CTRL_HALT_BIT] &
    ~option_reg.halt_disable & ~|(wake_en_reg & wake_pend_reg);
  assign idle_req = wr_ctrl & i_pwdata[power_save_pkg::CTRL_IDLE_BIT];

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      pins_prev_reg <= '0;
      clock_out_prev_reg <= 1'b0;
    end else begin
      pins_prev_reg <= i_wake_pins;
      clock_out_prev_reg <= i_clock_out_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // instruction-cycle divider and timers

  logic tc_tick;
  logic bit12_toggle;
  assign tc_tick = (state_reg != power_save_pkg::ST_HALT) &&
    div_reg == DIV_LAST;
  // bit eleven flips only when a counting tick carries out of the bits below
  assign bit12_toggle = tc_tick &&
    state_reg != power_save_pkg::ST_STARTUP &&
    (&idle_timer_reg[power_save_pkg::IDLE_TOGGLE_BIT-1:0]);

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      div_reg <= '0;
    end else if (state_reg == power_save_pkg::ST_HALT) begin
      div_reg <= '0;
    end else if (div_reg == DIV_LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      idle_timer_reg <= '0;
    end else if (tc_tick && state_reg != power_save_pkg::ST_STARTUP) begin
      idle_timer_reg <= idle_timer_reg + TW'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      startup_reg <= '0;
    end else if (state_reg == power_save_pkg::ST_HALT) begin
      startup_reg <= SU_LOAD;
    end else if (state_reg == power_save_pkg::ST_STARTUP && tc_tick) begin
      startup_reg <= startup_reg - SU_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power state machine

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_reg <= power_save_pkg::ST_RUN;
    end else begin
      unique case (state_reg)
        power_save_pkg::ST_RUN: begin
          if (halt_req) begin
            state_reg <= power_save_pkg::ST_HALT;
          end else if (idle_req) begin
            state_reg <= power_save_pkg::ST_IDLE;
          end
        end
        power_save_pkg::ST_HALT: begin
          if (halt_wake) begin
            if (option_reg.rc_osc_select &&
                !ctrl_reg.rc_startup_delay_enable) begin
              state_reg <= power_save_pkg::ST_RUN;
            end else begin
              state_reg <= power_save_pkg::ST_STARTUP;
            end
          end
        end
        power_save_pkg::ST_STARTUP: begin
          if (tc_tick && startup_reg == SU_W'(1)) begin
            state_reg <= power_save_pkg::ST_RUN;
          end
        end
        power_save_pkg::ST_IDLE: begin
          if (pin_wake || bit12_toggle) begin
            state_reg <= power_save_pkg::ST_RUN;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ctrl_reg <= power_save_pkg::ctrl_t'(
        power_save_pkg::CTRL_RESET[power_save_pkg::CTRL_WAKE_TIMER_IRQ_ENABLE_BIT:
                                   power_save_pkg::CTRL_RC_STARTUP_DELAY_ENABLE_BIT]);
    end else if (wr_ctrl) begin
      ctrl_reg <= power_save_pkg::ctrl_t'(
        i_pwdata[power_save_pkg::CTRL_WAKE_TIMER_IRQ_ENABLE_BIT:
                 power_save_pkg::CTRL_RC_STARTUP_DELAY_ENABLE_BIT]);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      option_reg <= '0;
    end else if (wr_opt) begin
      option_reg <= power_save_pkg::option_t'(
        i_pwdata[power_save_pkg::OPT_RC_OSC_BIT:
                 power_save_pkg::OPT_HALT_DIS_BIT]);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wake_en_reg <= '0;
      wake_edge_reg <= '0;
    end else begin
      if (wr_wen) begin
        wake_en_reg <= i_pwdata[WAKE_PINS-1:0];
      end
      if (wr_wedge) begin
        wake_edge_reg <= i_pwdata[WAKE_PINS-1:0];
      end
    end
  end

  // pending edges: a new edge wins over a write-one clear
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      wake_pend_reg <= '0;
    end else begin
      wake_pend_reg <= (wake_pend_reg &
        ~(wr_wpend ? i_pwdata[WAKE_PINS-1:0] : '0)) | pin_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [power_save_pkg::EV_WIDTH-1:0] events;
  always_comb begin
    events = '0;
    events[power_save_pkg::EV_WAKE_TIMER_BIT] = bit12_toggle;
    events[power_save_pkg::EV_WAKE_PIN_BIT] = pin_wake;
    events[power_save_pkg::EV_HALT_EXIT_BIT] =
      state_reg == power_save_pkg::ST_HALT && halt_wake;
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg &
        ~(wr_irqs ? i_pwdata[power_save_pkg::EV_WIDTH-1:0] : '0)) | events;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      irq_mask_reg <= '0;
    end else if (wr_mask) begin
      irq_mask_reg <= i_pwdata[power_save_pkg::EV_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (addr)
      power_save_pkg::CTRL_OFS: begin
        // halt flag reads zero when disabled
        rd_mux[power_save_pkg::CTRL_HALT_BIT] =
          state_reg == power_save_pkg::ST_HALT;
        rd_mux[power_save_pkg::CTRL_IDLE_BIT] =
          state_reg == power_save_pkg::ST_IDLE;
        rd_mux[power_save_pkg::CTRL_WAKE_TIMER_IRQ_ENABLE_BIT:
               power_save_pkg::CTRL_RC_STARTUP_DELAY_ENABLE_BIT] = ctrl_reg;
      end
      power_save_pkg::OPTION_CONFIG_OFS: begin
        rd_mux[power_save_pkg::OPT_RC_OSC_BIT:
               power_save_pkg::OPT_HALT_DIS_BIT] = option_reg;
      end
      power_save_pkg::WAKE_EN_OFS: rd_mux[WAKE_PINS-1:0] = wake_en_reg;
      power_save_pkg::WAKE_EDGE_OFS: rd_mux[WAKE_PINS-1:0] = wake_edge_reg;
      power_save_pkg::WAKE_PEND_OFS: rd_mux[WAKE_PINS-1:0] = wake_pend_reg;
      power_save_pkg::STATUS_OFS: begin
        rd_mux[TW-1:0] = idle_timer_reg;
        rd_mux[TW+1:TW] = state_reg;
      end
      power_save_pkg::IRQ_STATUS_OFS: begin
        rd_mux[power_save_pkg::EV_WIDTH-1:0] = irq_status_reg;
      end
      power_save_pkg::IRQ_MASK_OFS: begin
        rd_mux[power_save_pkg::EV_WIDTH-1:0] = irq_mask_reg;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // one wait-free access phase: ready rises the cycle after setup
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup & ~rd_hit;
      o_prdata <= (setup & ~i_pwrite) ? rd_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power outputs

  power_save_pkg::pwr_state_t state_next;
  always_comb begin
    state_next = state_reg;
    if (state_reg == power_save_pkg::ST_RUN && halt_req) begin
      state_next = power_save_pkg::ST_HALT;
    end else if (state_reg == power_save_pkg::ST_RUN && idle_req) begin
      state_next = power_save_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_core_clock_enable <= 1'b1;
      o_oscillator_enable <= 1'b1;
      o_idle_timer_running <= 1'b1;
      o_watchdog_enable <= 1'b1;
      o_watchdog_fault_output_n <= 1'b1;
      o_clock_in_hold_high <= 1'b0;
      o_clock_in_hiz <= 1'b0;
      o_wake_timer_irq <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_core_clock_enable <= state_reg == power_save_pkg::ST_RUN &&
        state_next == power_save_pkg::ST_RUN;
      o_oscillator_enable <= state_next != power_save_pkg::ST_HALT;
      o_idle_timer_running <= state_next != power_save_pkg::ST_HALT;
      o_watchdog_enable <= state_next != power_save_pkg::ST_HALT;
      o_watchdog_fault_output_n <= ~(ctrl_reg.clock_monitor_enable &&
        state_next == power_save_pkg::ST_HALT);
      o_clock_in_hold_high <= state_next == power_save_pkg::ST_HALT &&
        option_reg.rc_osc_select;
      o_clock_in_hiz <= state_next == power_save_pkg::ST_HALT &&
        !option_reg.rc_osc_select;
      // irq drives the isr after idle
      o_wake_timer_irq <= ctrl_reg.wake_timer_irq_enable &
        irq_status_reg[power_save_pkg::EV_WAKE_TIMER_BIT];
      o_irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

endmodule // power_save_mode_control

`default_nettype wire

// file: design/power_save_pkg.sv
/*
  power_save_pkg: register map, field positions, reset values, timing
  constants and types for the power save mode controller.
  Assumes a 32-bit APB master and a core oscillator clock on i_clock.
*/
package power_save_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OPTION_CONFIG_OFS = 8'h04;
  localparam logic [7:0] WAKE_EN_OFS = 8'h08;
  localparam logic [7:0] WAKE_EDGE_OFS = 8'h0c;
  localparam logic [7:0] WAKE_PEND_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;

  // control register fields
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_IDLE_BIT = 1;
  localparam int CTRL_RC_STARTUP_DELAY_ENABLE_BIT = 2;
  localparam int CTRL_CLKMON_BIT = 3;
  localparam int CTRL_WAKE_TIMER_IRQ_ENABLE_BIT = 4;

  // option configuration fields
  localparam int OPT_HALT_DIS_BIT = 0;
  localparam int OPT_RC_OSC_BIT = 1;

  // event bits, shared by irq status and irq mask
  localparam int EV_WAKE_TIMER_BIT = 0;
  localparam int EV_WAKE_PIN_BIT = 1;
  localparam int EV_HALT_EXIT_BIT = 2;
  localparam int EV_WIDTH = 3;

  // timing
  localparam int TC_DIVIDE = 10;
  localparam int STARTUP_LOAD = 256;
  localparam int IDLE_TOGGLE_BIT = 11;
  localparam int IDLE_TIMER_WIDTH = 16;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_STARTUP,
    ST_IDLE
  } pwr_state_t;

  // software control fields
  typedef struct packed {
    logic wake_timer_irq_enable;
    logic clock_monitor_enable;
    logic rc_startup_delay_enable;
  } ctrl_t;

  // option configuration fields
  typedef struct packed {
    logic rc_osc_select;
    logic halt_disable;
  } option_t;

endpackage

// file: testbench/power_save_mode_control_asserts.sv
/*
  power_save_checker: port properties of the power save controller.
  Assumes binding into power_save_mode_control on i_clock and i_nrst.
*/
`timescale 1ns/1ps
`default_nettype none
module power_save_checker (
  // clock, reset and bus
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  // power control
  input wire logic o_core_clock_enable,
  input wire logic o_oscillator_enable,
  input wire logic o_idle_timer_running,
  input wire logic o_watchdog_enable,
  input wire logic o_watchdog_fault_output_n,
  input wire logic o_clock_in_hold_high,
  input wire logic o_clock_in_hiz
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [15:0] dark_cnt;
  logic from_halt;
  logic rc_halt;
  //////////////////////////////////////////////////////////////////////
  // cycles with oscillator up and core clock gated
  always_ff @(posedge i_clock) begin
    if (!i_nrst || o_core_clock_enable || !o_oscillator_enable) begin
      dark_cnt <= 16'h0000;
    end else begin
      dark_cnt <= dark_cnt + 16'h0001;
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_nrst || o_core_clock_enable) begin
      from_halt <= 1'b0;
      rc_halt <= 1'b0;
    end else if (!o_oscillator_enable) begin
      from_halt <= 1'b1;
      rc_halt <= o_clock_in_hold_high;
    end
  end
  stop_all_a: assert property (
    !o_oscillator_enable |-> !o_core_clock_enable && !o_idle_timer_running)
    else $error("clock or timer running in deep stop");
  watchdog_off_a: assert property (
    !o_oscillator_enable |-> !o_watchdog_enable)
    else $error("watchdog active in deep stop");
  fault_pin_a: assert property (
    !o_watchdog_fault_output_n |-> !o_oscillator_enable)
    else $error("fault output low outside deep stop");
  clk_pin_a: assert property (
    !o_oscillator_enable |-> o_clock_in_hold_high != o_clock_in_hiz)
    else $error("clock input pin mode wrong in deep stop");
  pin_free_a: assert property (
    o_core_clock_enable |-> !o_clock_in_hold_high && !o_clock_in_hiz)
    else $error("clock input pin held while running");
  idle_keep_a: assert property (
    o_oscillator_enable && !o_core_clock_enable |-> o_idle_timer_running)
    else $error("idle timer stopped in light sleep");
  startup_len_a: assert property (
    $rose(o_core_clock_enable) && from_halt && !rc_halt
      |-> dark_cnt inside {[16'h09c4:16'h0a50]})
    else $error("start-up delay length wrong");
  idle_bound_a: assert property (
    dark_cnt <= 16'h5014)
    else $error("light sleep outlived the idle timer toggle");
  apb_ready_a: assert property (
    i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("ready not a single cycle after setup");
endmodule // power_save_checker
bind power_save_mode_control power_save_checker checker_i (
  .i_clock, .i_nrst, .i_psel, .i_penable, .o_pready,
  .o_core_clock_enable, .o_oscillator_enable, .o_idle_timer_running,
  .o_watchdog_enable, .o_watchdog_fault_output_n,
  .o_clock_in_hold_high, .o_clock_in_hiz
);
`default_nettype wire

// file: testbench/wake_source_model.sv
/*
  wake_source_model: the wake port and clock-out pin seen from outside.
  Assumes one-cycle fire commands from the bench on i_clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wake_source_model (
  // clock and command
  input wire logic i_clock,
  input wire logic i_fire,
  input wire logic [3:0] i_lag,
  input wire logic [3:0] i_sel,
  // pins
  output logic [7:0] o_wake_pins,
  output logic o_clock_out_pin
);
  logic [3:0] wait_cnt = 4'h0;
  logic [3:0] sel_reg = 4'h0;
  logic armed = 1'b0;
  initial begin
    o_wake_pins = 8'h00;
    o_clock_out_pin = 1'b0;
  end
  // edge on a pin after a lag
  always @(posedge i_clock) begin
    if (i_fire) begin
      armed <= 1'b1;
      wait_cnt <= i_lag;
      sel_reg <= i_sel;
    end else if (armed && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (armed) begin
      armed <= 1'b0;
      if (sel_reg[3]) o_clock_out_pin <= !o_clock_out_pin;
      else o_wake_pins[sel_reg[2:0]] <= !o_wake_pins[sel_reg[2:0]];
    end
  end
endmodule // wake_source_model
`default_nettype wire

// file: testbench/power_save_mode_control_bench.sv
/*
  power_save_mode_control_bench: directed scenarios over APB and pins.
  Assumes the package, the design, the checker and the wake model.
*/
`timescale 1ns/1ps
`default_nettype none
module power_save_mode_control_bench;
  localparam logic [31:0] HALT = 32'h1 << power_save_pkg::CTRL_HALT_BIT;
  localparam logic [31:0] IDLE = 32'h1 << power_save_pkg::CTRL_IDLE_BIT;
  localparam logic [31:0] DLY = 32'h1 << power_save_pkg::CTRL_RC_STARTUP_DELAY_ENABLE_BIT;
  localparam logic [31:0] MON = 32'h1 << power_save_pkg::CTRL_CLKMON_BIT;
  localparam logic [31:0] TEN = 32'h1 << power_save_pkg::CTRL_WAKE_TIMER_IRQ_ENABLE_BIT;
  logic clk, nrst, psel, penable, pwrite, pready, serr, slv, fire, clock_out_pin;
  logic [7:0] paddr, pins;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] lag, sel;
  logic core, osc, tmr, wd, fault_n, hold, hiz, wtirq, irq;
  int err_total, n_tests, n;
  always #2 clk = ~clk;
  wake_source_model partner (.i_clock(clk), .i_fire(fire), .i_lag(lag),
    .i_sel(sel), .o_wake_pins(pins), .o_clock_out_pin(clock_out_pin));
  power_save_mode_control dut (
    .i_clock(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(serr),
    .i_wake_pins(pins), .i_clock_out_pin(clock_out_pin),
    .o_core_clock_enable(core), .o_oscillator_enable(osc),
    .o_idle_timer_running(tmr), .o_watchdog_enable(wd),
    .o_watchdog_fault_output_n(fault_n), .o_clock_in_hold_high(hold),
    .o_clock_in_hiz(hiz), .o_wake_timer_irq(wtirq), .o_irq(irq));
  //////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    test_done();
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad,
      input logic [31:0] v);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdat = prdata;
    slv = serr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (k >= 16) hang();
  endtask
  task automatic kick(input logic [3:0] s, input logic [3:0] l);
    sel <= s;
    lag <= l;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  task automatic wait_core();
    n = 0;
    while (core !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 30000) hang();
    end
  endtask
  task automatic t_reset_vals();
    apb(0, power_save_pkg::CTRL_OFS, 0);
    chk("ctrl", power_save_pkg::CTRL_RESET, rdat);
    apb(1, 8'h24, 32'hffff_ffff);
    chk("slverr", 1, slv);
  endtask
  task automatic t_halt_pin();
    apb(1, power_save_pkg::WAKE_EN_OFS, 32'h1);
    apb(1, power_save_pkg::IRQ_MASK_OFS, 32'h4);
    apb(1, power_save_pkg::CTRL_OFS, HALT | MON);
    repeat (3) @(posedge clk);
    chk("core", 0, core);
    chk("wdog", 0, wd);
    chk("fault", 0, fault_n);
    chk("hiz", 1, hiz);
    kick(4'h0, 4'h9);
    repeat (14) @(posedge clk);
    chk("osc", 1, osc & ~core);
    wait_core();
    chk("startup", 1, n >= 2480 && n <= 2620);
    repeat (3) @(posedge clk);
    chk("irq", 1, irq);
    apb(1, power_save_pkg::IRQ_MASK_OFS, 0);
    @(posedge clk);
    chk("masked", 0, irq);
    apb(1, power_save_pkg::IRQ_STATUS_OFS, 32'h7);
    apb(1, power_save_pkg::IRQ_MASK_OFS, 32'h4);
    @(posedge clk);
    chk("cleared", 0, irq);
  endtask
  task automatic t_refuse();
    apb(1, power_save_pkg::CTRL_OFS, HALT | MON);
    repeat (3) @(posedge clk);
    chk("pend stop", 1, core);
    apb(1, power_save_pkg::WAKE_PEND_OFS, 32'h1);
    apb(1, power_save_pkg::OPTION_CONFIG_OFS, 32'h1);
    apb(1, power_save_pkg::CTRL_OFS, HALT | MON);
    repeat (3) @(posedge clk);
    chk("dis stop", 1, core);
    apb(0, power_save_pkg::CTRL_OFS, 0);
    chk("halt flag", 0, rdat[power_save_pkg::CTRL_HALT_BIT]);
  endtask
  task automatic t_rc();
    apb(1, power_save_pkg::OPTION_CONFIG_OFS, 32'h2);
    apb(1, power_save_pkg::CTRL_OFS, HALT);
    repeat (3) @(posedge clk);
    chk("hold", 1, hold);
    chk("no fault", 1, fault_n);
    kick(4'h8, 4'h0);
    wait_core();
    chk("rc fast", 1, n < 20);
    apb(1, power_save_pkg::CTRL_OFS, HALT | DLY);
    kick(4'h8, 4'h0);
    repeat (6) @(posedge clk);
    chk("cko fall", 0, osc);
    kick(4'h8, 4'h3);
    wait_core();
    chk("rc delay", 1, n >= 2480 && n <= 2620);
  endtask
  task automatic t_idle();
    apb(1, power_save_pkg::OPTION_CONFIG_OFS, 0);
    apb(1, power_save_pkg::IRQ_STATUS_OFS, 32'h7);
    apb(1, power_save_pkg::IRQ_MASK_OFS, 32'h1);
    apb(1, power_save_pkg::CTRL_OFS, IDLE | TEN);
    repeat (3) @(posedge clk);
    chk("idle", 3'b010, {core, osc, tmr} ^ 3'b001);
    wait_core();
    chk("toggle", 1, n <= 20500);
    repeat (3) @(posedge clk);
    chk("t irq", 2'b11, {wtirq, irq});
    apb(1, power_save_pkg::WAKE_EDGE_OFS, 32'h2);
    apb(1, power_save_pkg::WAKE_EN_OFS, 32'h3);
    apb(1, power_save_pkg::CTRL_OFS, IDLE);
    kick(4'h1, 4'h0);
    repeat (5) @(posedge clk);
    chk("rise", 0, core);
    kick(4'h1, 4'h0);
    wait_core();
    chk("pin wake", 1, n < 20);
    chk("no t irq", 0, wtirq);
    apb(0, power_save_pkg::WAKE_EN_OFS, 0);
    chk("kept", 32'h3, rdat);
    apb(0, power_save_pkg::STATUS_OFS, 0);
    chk("run state", 0, rdat[17:16]);
  endtask
  task automatic t_reset_idle();
    apb(1, power_save_pkg::CTRL_OFS, IDLE | DLY);
    repeat (3) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("reset exit", 1, core);
    apb(0, power_save_pkg::CTRL_OFS, 0);
    chk("dly cleared", 0, rdat[power_save_pkg::CTRL_RC_STARTUP_DELAY_ENABLE_BIT]);
  endtask
  initial begin
    clk = 0;
    nrst = 0;
    {psel, penable, pwrite, fire} = 4'h0;
    {paddr, pwdata, lag, sel} = 48'h0;
    err_total = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset_vals();
    t_halt_pin();
    t_refuse();
    t_rc();
    t_idle();
    t_reset_idle();
    test_done();
  end
endmodule // power_save_mode_control_bench
`default_nettype wire
